// ==== common/rx_rate_pkg.sv ====
// Constants, codes and helpers shared by the receive rate adapter
package rx_rate_pkg;

  // ---------------------------------------------------------------
  // Clock and rate figures, in kHz
  // ---------------------------------------------------------------
  localparam int REF_KHZ = 125000;
  localparam int RATE_KHZ_1000 = 125000;
  localparam int RATE_KHZ_100 = 12500;
  localparam int RATE_KHZ_10 = 1250;
  localparam int PHASE_KHZ_100 = 25000;
  localparam int PHASE_KHZ_10 = 2500;

  // ---------------------------------------------------------------
  // Derived cycle counts
  // ---------------------------------------------------------------
  localparam int CNT_W = 7;
  localparam logic [6:0] DIV_1000 = 7'(REF_KHZ / RATE_KHZ_1000);
  localparam logic [6:0] DIV_100 = 7'(REF_KHZ / RATE_KHZ_100);
  localparam logic [6:0] DIV_10 = 7'(REF_KHZ / RATE_KHZ_10);
  localparam logic [6:0] PER_FULL = 7'h01;
  localparam logic [6:0] PER_100 = 7'(REF_KHZ / PHASE_KHZ_100);
  localparam logic [6:0] PER_10 = 7'(REF_KHZ / PHASE_KHZ_10);
  localparam logic [6:0] CNT_RST = 7'h00;

  // ---------------------------------------------------------------
  // Speed codes and data word layout
  // ---------------------------------------------------------------
  localparam logic [1:0] SPD_10 = 2'h0;
  localparam logic [1:0] SPD_100 = 2'h1;
  localparam logic [1:0] SPD_1000 = 2'h2;
  localparam int WORD_W = 10;
  localparam int FIFO_D = 8;
  localparam int W_DV = 9;
  localparam int W_ER = 8;
  localparam logic [7:0] SFD = 8'hd5;
  localparam logic [3:0] SFD_LO = 4'hd;
  localparam logic [3:0] PRE_HI = 4'h5;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [3:0] NIB_RST = 4'h0;

  typedef enum logic [1:0] {AL_HUNT, AL_DIRECT, AL_SHIFT} align_e;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [6:0] rate_div(input logic [1:0] spd);
    logic [6:0] d;
    d = DIV_1000;
    if (spd == SPD_100) begin
      d = DIV_100;
    end else if (spd == SPD_10) begin
      d = DIV_10;
    end
    return d;
  endfunction

  function automatic logic [6:0] phase_per(input logic [1:0] spd,
                                           input logic phy);
    logic [6:0] p;
    p = PER_FULL;
    if (phy && spd == SPD_100) begin
      p = PER_100;
    end else if (phy && spd == SPD_10) begin
      p = PER_10;
    end
    return p;
  endfunction

endpackage

// ==== rtl/byte_fifo.sv ====
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/100ps
module byte_fifo #(
  parameter int W = 10,
  parameter int D = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  // ---------------------------------------------------------------
  // Pointers and fill level
  // ---------------------------------------------------------------
  always_comb begin
    in_ready_o = (cnt_r != (AW+1)'(D));
    out_valid_o = (cnt_r != '0);
    out_data_o = mem_r[rp_r];
    push = in_valid_i && in_ready_o;
    pop = out_valid_o && out_ready_i;
    wp_nxt = push ? ((wp_r == AW'(D-1)) ? '0 : wp_r + 1'b1) : wp_r;
    rp_nxt = pop ? ((rp_r == AW'(D-1)) ? '0 : rp_r + 1'b1) : rp_r;
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else if (ce_i) begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Storage holds no reset, contents are guarded by the count
  always_ff @(posedge clk_i) begin
    if (ce_i && push) begin
      mem_r[wp_r] <= in_data_i;
    end
  end

endmodule // byte_fifo

// ==== rtl/rx_rate_adapt.sv ====
// Receive rate adapter with clock enable and clock phase generator
//
// Overview of operation
// - At 1 Gb/s every reference cycle carries a byte passed straight on.
// - At 100 and 10 Mb/s each byte repeats for 10 or 100 cycles.
// - Bytes are captured only on cycles where the rate enable is high.
// - In MAC mode a start delimiter split over two bytes is realigned.
// - In PHY mode at MII speeds the low nibble goes out before the high.
// - The PHY mode nibble sequence advances only on the nibble enable.
// - The rate enable runs at 125, 12.5 or 1.25 MHz by speed.
// - The forwarded client clock is built from rise and fall phases.
// - Phases run at 125 MHz in MAC mode or at 1 Gb/s, else 25 or 2.5 MHz.
// - The phases feed a double data rate output register.
// - Sampled data leaves on the GMII-style receive interface.
`timescale 1ns/100ps
module rx_rate_adapt (
  input wire logic MCLK_I,
  input wire logic RESET_I,
  input wire logic CE_I,
  input wire logic LINK_CLK_I,
  input wire logic LINK_VALID_I,
  output logic LINK_READY_O,
  input wire logic [7:0] LINK_DATA_I,
  input wire logic LINK_DV_I,
  input wire logic LINK_ER_I,
  input wire logic [1:0] SPEED_I,
  input wire logic PHY_MODE_I,
  output logic [7:0] RX_DATA_O,
  output logic RX_DV_O,
  output logic RX_ER_O,
  output logic CLK_EN_O,
  output logic NIB_CLK_EN_O,
  output logic CLK_RISE_O,
  output logic CLK_FALL_O
);
  import rx_rate_pkg::*;

  // ---------------------------------------------------------------
  // Link domain: reset and enable brought over, word handshake
  // ---------------------------------------------------------------
  logic lrst_m, lrst_s, lce_m, lce_s, ack_m, ack_s, ack_r;
  logic req_r, req_nxt;
  logic [WORD_W-1:0] word_r, word_nxt;
  logic link_take;

  always_ff @(posedge LINK_CLK_I) begin
    lrst_m <= RESET_I;
    lrst_s <= lrst_m;
    lce_m <= CE_I;
    lce_s <= lce_m;
    ack_m <= ack_r;
    ack_s <= ack_m;
  end

  // One word in flight; the link is held off until it is taken
  always_comb begin
    LINK_READY_O = (req_r == ack_s) && lce_s && !lrst_s;
    link_take = LINK_VALID_I && LINK_READY_O;
    req_nxt = req_r ^ link_take;
    word_nxt = link_take ? {LINK_DV_I, LINK_ER_I, LINK_DATA_I} : word_r;
  end

  always_ff @(posedge LINK_CLK_I) begin
    if (lrst_s) begin
      req_r <= 1'b0;
      word_r <= '0;
    end else if (lce_s) begin
      req_r <= req_nxt;
      word_r <= word_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Reference domain: handshake receive into the FIFO
  // ---------------------------------------------------------------
  logic req_m, req_s, ack_nxt;
  logic push, f_in_ready, f_out_valid;
  logic [WORD_W-1:0] f_out_data;
  logic rate_en, nib_en;

  always_ff @(posedge MCLK_I) begin
    req_m <= req_r;
    req_s <= req_m;
  end

  // Word is stable while pending, so it is read without resampling
  always_comb begin
    push = (req_s != ack_r) && f_in_ready;
    ack_nxt = ack_r ^ push;
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      ack_r <= 1'b0;
    end else if (CE_I) begin
      ack_r <= ack_nxt;
    end
  end

  // Drained only in capture slots, so slow speeds back up to the link
  byte_fifo #(
    .W(WORD_W),
    .D(FIFO_D)
  ) u_fifo (
    .clk_i(MCLK_I),
    .rst_i(RESET_I),
    .ce_i(CE_I),
    .in_valid_i(push),
    .in_ready_o(f_in_ready),
    .in_data_i(word_r),
    .out_valid_o(f_out_valid),
    .out_ready_i(rate_en),
    .out_data_o(f_out_data)
  );

  // ---------------------------------------------------------------
  // Rate and nibble enables, clock phases
  // ---------------------------------------------------------------
  logic [1:0] speed_r, speed_nxt;
  logic [6:0] rate_cnt_r, rate_cnt_nxt, phase_cnt_r, phase_cnt_nxt;
  logic [6:0] div, per;
  logic rise_r, rise_nxt, fall_r, fall_nxt, spd_chg;

  always_comb begin
    div = rate_div(speed_r);
    per = phase_per(speed_r, PHY_MODE_I);
    spd_chg = (SPEED_I != speed_r);
    speed_nxt = SPEED_I;
    rate_en = (rate_cnt_r == CNT_RST);
    nib_en = rate_en || (rate_cnt_r == (div >> 1));
    rate_cnt_nxt = rate_cnt_r + 7'h01;
    if (spd_chg || rate_cnt_r == div - 7'h01) begin
      rate_cnt_nxt = CNT_RST;
    end
    phase_cnt_nxt = phase_cnt_r + 7'h01;
    if (spd_chg || phase_cnt_r >= per - 7'h01) begin
      phase_cnt_nxt = CNT_RST;
    end
    // Each cycle is two half periods: rise half then fall half
    rise_nxt = ({phase_cnt_nxt, 1'b0} < {1'b0, per});
    fall_nxt = ({phase_cnt_nxt, 1'b1} < {1'b0, per});
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      speed_r <= SPD_1000;
      rate_cnt_r <= CNT_RST;
      phase_cnt_r <= CNT_RST;
      rise_r <= 1'b0;
      fall_r <= 1'b0;
    end else if (CE_I) begin
      speed_r <= speed_nxt;
      rate_cnt_r <= rate_cnt_nxt;
      phase_cnt_r <= phase_cnt_nxt;
      rise_r <= rise_nxt;
      fall_r <= fall_nxt;
    end
  end

  // Phase pair drives an output DDR register for the client clock
  assign CLK_RISE_O = rise_r;
  assign CLK_FALL_O = fall_r;
  assign CLK_EN_O = rate_en;
  assign NIB_CLK_EN_O = nib_en;

  // ---------------------------------------------------------------
  // Capture, delimiter alignment and nibble sequencing
  // ---------------------------------------------------------------
  align_e al_r, al_nxt;
  logic [7:0] out_r, out_nxt, hold_r, hold_nxt, cur;
  logic [3:0] prev_hi_r, prev_hi_nxt;
  logic dv_r, dv_nxt, er_r, er_nxt, mii, take, dv_in;

  always_comb begin
    mii = PHY_MODE_I && (speed_r != SPD_1000);
    take = rate_en;
    cur = f_out_valid ? f_out_data[7:0] : BYTE_RST;
    dv_in = f_out_valid && f_out_data[W_DV];
    al_nxt = al_r;
    out_nxt = out_r;
    hold_nxt = hold_r;
    prev_hi_nxt = prev_hi_r;
    dv_nxt = dv_r;
    er_nxt = er_r;
    if (take && !mii) begin
      out_nxt = cur;
      dv_nxt = dv_in;
      er_nxt = f_out_valid && f_out_data[W_ER];
      prev_hi_nxt = cur[7:4];
      case (al_r)
        AL_HUNT: begin
          if (dv_in && cur == SFD) begin
            al_nxt = AL_DIRECT;
          end else if (dv_in && !PHY_MODE_I && cur[3:0] == SFD_LO &&
                       prev_hi_r == PRE_HI) begin
            al_nxt = AL_SHIFT;
            out_nxt = {cur[3:0], prev_hi_r};
          end
        end
        AL_DIRECT: begin
          if (!dv_in) begin
            al_nxt = AL_HUNT;
          end
        end
        AL_SHIFT: begin
          // Final half byte of a skewed frame is dropped with the frame
          out_nxt = {cur[3:0], prev_hi_r};
          if (!dv_in) begin
            al_nxt = AL_HUNT;
            out_nxt = cur;
          end
        end
        default: begin
          al_nxt = AL_HUNT;
        end
      endcase
    end else if (take) begin
      hold_nxt = cur;
      out_nxt = {NIB_RST, cur[3:0]};
      dv_nxt = dv_in;
      er_nxt = f_out_valid && f_out_data[W_ER];
      al_nxt = AL_HUNT;
    end else if (mii && nib_en) begin
      out_nxt = {NIB_RST, hold_r[7:4]};
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      al_r <= AL_HUNT;
      out_r <= BYTE_RST;
      hold_r <= BYTE_RST;
      prev_hi_r <= NIB_RST;
      dv_r <= 1'b0;
      er_r <= 1'b0;
    end else if (CE_I) begin
      al_r <= al_nxt;
      out_r <= out_nxt;
      hold_r <= hold_nxt;
      prev_hi_r <= prev_hi_nxt;
      dv_r <= dv_nxt;
      er_r <= er_nxt;
    end
  end

  assign RX_DATA_O = out_r;
  assign RX_DV_O = dv_r;
  assign RX_ER_O = er_r;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  logic past_chg;
  always_ff @(posedge MCLK_I) begin
    past_chg <= spd_chg;
  end

  property p_full_rate;
    @(posedge MCLK_I) disable iff (RESET_I || !CE_I)
    (speed_r == SPD_1000 && !spd_chg) |-> (CLK_EN_O && NIB_CLK_EN_O);
  endproperty
  a_full_rate: assert property (p_full_rate)
    else $error("rate enable missing at 1 Gb/s");

  property p_gap_100;
    @(posedge MCLK_I) disable iff (RESET_I || !CE_I || spd_chg)
    (CLK_EN_O && speed_r == SPD_100) |=> (!CLK_EN_O [*8]) ##1
      (!CLK_EN_O) ##1 CLK_EN_O;
  endproperty
  a_gap_100: assert property (p_gap_100)
    else $error("rate enable spacing wrong at 100 Mb/s");

  property p_gap_10;
    @(posedge MCLK_I) disable iff (RESET_I || !CE_I || spd_chg)
    (CLK_EN_O && speed_r == SPD_10) |-> ##100 CLK_EN_O;
  endproperty
  a_gap_10: assert property (p_gap_10)
    else $error("rate enable period wrong at 10 Mb/s");

  property p_hold_mac;
    @(posedge MCLK_I) disable iff (RESET_I)
    (!PHY_MODE_I && !(CE_I && CLK_EN_O)) |=> $stable(RX_DATA_O);
  endproperty
  a_hold_mac: assert property (p_hold_mac)
    else $error("byte changed outside a capture slot");

  property p_sfd_fix;
    @(posedge MCLK_I) disable iff (RESET_I || !CE_I)
    (!PHY_MODE_I && CLK_EN_O && al_r == AL_HUNT && dv_in &&
     cur[3:0] == SFD_LO && cur != SFD && prev_hi_r == PRE_HI)
      |=> (RX_DATA_O == SFD && RX_DV_O);
  endproperty
  a_sfd_fix: assert property (p_sfd_fix)
    else $error("skewed delimiter not realigned");

  property p_nib_lo;
    @(posedge MCLK_I) disable iff (RESET_I || !CE_I)
    (mii && CLK_EN_O) |=> (RX_DATA_O[3:0] == $past(cur[3:0]));
  endproperty
  a_nib_lo: assert property (p_nib_lo)
    else $error("low nibble not first");

  property p_nib_hi;
    @(posedge MCLK_I) disable iff (RESET_I || !CE_I)
    (mii && NIB_CLK_EN_O && !CLK_EN_O) |=>
      (RX_DATA_O[3:0] == $past(hold_r[7:4]));
  endproperty
  a_nib_hi: assert property (p_nib_hi)
    else $error("high nibble not second");

  property p_nib_step;
    @(posedge MCLK_I) disable iff (RESET_I)
    (mii && !(CE_I && NIB_CLK_EN_O)) |=> $stable(RX_DATA_O[3:0]);
  endproperty
  a_nib_step: assert property (p_nib_step)
    else $error("nibble moved without nibble enable");

  property p_nib_mid;
    @(posedge MCLK_I) disable iff (RESET_I || !CE_I || spd_chg)
    (CLK_EN_O && speed_r == SPD_100) |-> ##5 (NIB_CLK_EN_O && !CLK_EN_O);
  endproperty
  a_nib_mid: assert property (p_nib_mid)
    else $error("second nibble enable not mid period");

  property p_phase_mac;
    @(posedge MCLK_I) disable iff (RESET_I || !CE_I || past_chg)
    (!PHY_MODE_I && $stable(PHY_MODE_I)) |=> (CLK_RISE_O && !CLK_FALL_O);
  endproperty
  a_phase_mac: assert property (p_phase_mac)
    else $error("phases not at full rate in MAC mode");

  property p_phase_100;
    @(posedge MCLK_I) disable iff (RESET_I || !CE_I || spd_chg)
    (PHY_MODE_I && speed_r == SPD_100 && CLK_RISE_O && CLK_FALL_O &&
     $past(!CLK_RISE_O)) |-> ##1 (CLK_RISE_O && CLK_FALL_O) ##1
      (CLK_RISE_O && !CLK_FALL_O) ##1 (!CLK_RISE_O) ##1 (!CLK_RISE_O)
      ##1 CLK_RISE_O;
  endproperty
  a_phase_100: assert property (p_phase_100)
    else $error("phase pattern wrong at 100 Mb/s");

  property p_restart;
    @(posedge MCLK_I) disable iff (RESET_I || !CE_I)
    spd_chg |=> (CLK_EN_O && phase_cnt_r == CNT_RST);
  endproperty
  a_restart: assert property (p_restart)
    else $error("counters not restarted on speed change");

  c_sfd_fix: cover property (@(posedge MCLK_I) al_r == AL_SHIFT);
  c_nib: cover property (@(posedge MCLK_I) mii && NIB_CLK_EN_O && RX_DV_O);
  c_chg: cover property (@(posedge MCLK_I) spd_chg && !RESET_I);
  c_full: cover property (@(posedge MCLK_I) !f_in_ready);

endmodule // rx_rate_adapt

// ==== tb/link_src_model.sv ====
// Link-side byte source standing in for the serial core
`timescale 1ns/100ps
module link_src_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ready_i,
  output logic valid_o,
  output logic [7:0] data_o,
  output logic dv_o,
  output logic er_o
);
  logic [9:0] q[$];
  int gap = 0;

  task automatic put(input logic [9:0] w);
    q.push_back(w);
  endtask

  initial begin
    valid_o = 1'b0;
    {dv_o, er_o, data_o} = 10'h000;
  end

  // ---------------------------------------------------------------
  // Word offer and release
  // ---------------------------------------------------------------
  always begin
    @(posedge clk_i);
    if (!rst_i && q.size() > 0) begin
      #1;
      {dv_o, er_o, data_o} = q.pop_front();
      valid_o = 1'b1;
      // Word and tags hold until the taking edge
      do @(posedge clk_i); while (ready_i !== 1'b1);
      #1;
      valid_o = 1'b0;
      // Released lines carry junk, never the old word
      {dv_o, er_o, data_o} = ~{dv_o, er_o, data_o};
      repeat (gap) @(posedge clk_i);
    end
  end
endmodule // link_src_model

// ==== tb/tb_rx_rate_adapt.sv ====
// Self-checking bench for the receive rate adapter
`timescale 1ns/100ps
module tb_rx_rate_adapt;
  import rx_rate_pkg::*;
  typedef logic [9:0] wq_t[$];
  logic mclk = 1'b0;
  logic lclk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [1:0] spd = SPD_1000;
  logic phy = 1'b0;
  logic l_valid, l_ready, l_dv, l_er;
  logic [7:0] l_data, rx_data;
  logic rx_dv, rx_er, clk_en, nib_en, c_rise, c_fall;
  logic [9:0] got[$];
  int fails = 0;
  int n_tests = 0;
  logic past_rise;

  always #5 mclk = ~mclk;
  always #24 lclk = ~lclk;

  rx_rate_adapt dut (.MCLK_I(mclk), .RESET_I(rst), .CE_I(ce),
    .LINK_CLK_I(lclk), .LINK_VALID_I(l_valid), .LINK_READY_O(l_ready),
    .LINK_DATA_I(l_data), .LINK_DV_I(l_dv), .LINK_ER_I(l_er),
    .SPEED_I(spd), .PHY_MODE_I(phy), .RX_DATA_O(rx_data),
    .RX_DV_O(rx_dv), .RX_ER_O(rx_er), .CLK_EN_O(clk_en),
    .NIB_CLK_EN_O(nib_en), .CLK_RISE_O(c_rise), .CLK_FALL_O(c_fall));

  link_src_model src (.clk_i(lclk), .rst_i(rst), .ready_i(l_ready),
    .valid_o(l_valid), .data_o(l_data), .dv_o(l_dv), .er_o(l_er));

  // ---------------------------------------------------------------
  // Client sampling and shared helpers
  // ---------------------------------------------------------------
  always @(posedge mclk) begin
    if (clk_en === 1'b1 && ce && rx_dv === 1'b1 && !phy) begin
      got.push_back({2'b00, rx_er, rx_data});
    end
  end

  task automatic check(input string what, input logic [9:0] seen,
                       input logic [9:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Offer words, optionally prove a stall, then collect the bytes
  task automatic xfer(input wq_t w, input wq_t e, input int lim,
                      input int stall_at, input string what);
    int hi;
    hi = 0;
    got.delete();
    foreach (w[i]) src.put(w[i]);
    if (stall_at > 0) begin
      tick(stall_at);
      // Longer than one link handshake, so a live ack would show
      for (int i = 0; i < 40; i++) begin
        tick(1);
        if (l_ready !== 1'b0) hi++;
      end
      check("link stall", 10'(hi), 10'h000);
    end
    for (int i = 0; i < lim && got.size() < e.size(); i++) tick(1);
    check({what, " count"}, 10'(got.size()), 10'(e.size()));
    foreach (e[i]) check(what, got[i], e[i]);
    $display("test %s done", what);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    tick(8);
    check("reset dv", 10'(rx_dv), 10'h000);
    check("reset en", 10'(clk_en), 10'h001);
    check("reset phases", 10'({c_rise, c_fall}), 10'h000);
    // Hold long enough for three link edges
    tick(8);
    check("reset ready", 10'(l_ready), 10'h000);
    rst = 1'b0;
    tick(4);
    $display("test reset done");
  endtask

  task automatic t_rate(input logic [1:0] s, input logic p, input int win,
                        input int en, input int rhi, input int fhi,
                        input int redg, input int nib);
    int n_en, n_rhi, n_fhi, n_redg, n_nib, seen;
    logic last;
    spd = s;
    phy = p;
    seen = 0;
    for (int i = 0; i < 3; i++) begin
      tick(1);
      if (clk_en === 1'b1) seen = 1;
    end
    check("restart", 10'(seen), 10'h001);
    {n_en, n_rhi, n_fhi, n_redg, n_nib} = '0;
    last = c_rise;
    for (int i = 0; i < win; i++) begin
      tick(1);
      n_en += int'(clk_en === 1'b1);
      n_rhi += int'(c_rise === 1'b1);
      n_fhi += int'(c_fall === 1'b1);
      n_nib += int'(nib_en === 1'b1);
      n_redg += int'(c_rise === 1'b1 && last === 1'b0);
      last = c_rise;
    end
    check("enable rate", 10'(n_en), 10'(en));
    check("rise high", 10'(n_rhi), 10'(rhi));
    check("fall high", 10'(n_fhi), 10'(fhi));
    check("rise edges", 10'(n_redg), 10'(redg));
    if (nib >= 0) check("nibble rate", 10'(n_nib), 10'(nib));
    $display("test rate speed %0d phy %0d done", s, p);
  endtask

  task automatic t_mac;
    spd = SPD_1000;
    phy = 1'b0;
    tick(5);
    xfer('{10'h255, 10'h255, 10'h2d5, 10'h212, 10'h334, 10'h000},
         '{10'h055, 10'h055, 10'h0d5, 10'h012, 10'h134}, 400, 0,
         "direct sfd");
    // Split delimiter needs back to back bytes; link keeps up at 10M only
    spd = SPD_10;
    tick(5);
    xfer('{10'h255, 10'h255, 10'h25d, 10'h221, 10'h243, 10'h000},
         '{10'h055, 10'h055, 10'h0d5, 10'h015, 10'h032}, 800, 0,
         "split sfd");
    // Leftover half byte must not appear once the frame ends
    tick(200);
    check("split tail", 10'(got.size()), 10'h005);
  endtask

  task automatic t_fifo;
    wq_t w, e;
    // Bounce the speed so the slot phase is known for the stall window
    spd = SPD_100;
    tick(2);
    spd = SPD_10;
    tick(5);
    for (int i = 0; i < 20; i++) begin
      w.push_back({2'b10, 8'(8'h60 + i)});
      e.push_back({2'b00, 8'(8'h60 + i)});
    end
    w.push_back(10'h000);
    xfer(w, e, 2300, 330, "fifo full at 10M");
  endtask

  task automatic t_nibble;
    int moved;
    spd = SPD_100;
    phy = 1'b1;
    src.gap = 3;
    tick(5);
    src.put(10'h2a7);
    src.put(10'h000);
    for (int i = 0; i < 300 && rx_dv !== 1'b1; i++) tick(1);
    check("low nibble", 10'(rx_data), 10'h007);
    for (int i = 0; i < 20 && nib_en !== 1'b1; i++) tick(1);
    check("nibble hold", 10'(rx_data), 10'h007);
    tick(1);
    check("high nibble", 10'(rx_data), 10'h00a);
    // Enable low must freeze the phase pattern
    ce = 1'b0;
    moved = 0;
    for (int i = 0; i < 30; i++) begin
      tick(1);
      if (c_rise !== 1'b1 && c_rise !== 1'b0) moved++;
      if (i > 2 && c_rise !== past_rise) moved++;
    end
    ce = 1'b1;
    src.gap = 0;
    check("frozen phase", 10'(moved), 10'h000);
    $display("test nibble done");
  endtask

  // Phase one edge back, to prove the freeze
  always @(posedge mclk) past_rise <= c_rise;

  initial begin
    t_reset;
    t_rate(SPD_1000, 1'b0, 50, 50, 50, 0, 0, -1);
    t_rate(SPD_100, 1'b0, 100, 10, 100, 0, 0, 20);
    t_rate(SPD_10, 1'b0, 1000, 10, 1000, 0, 0, 20);
    t_rate(SPD_1000, 1'b1, 50, 50, 50, 0, 0, -1);
    t_rate(SPD_100, 1'b1, 100, 10, 60, 40, 20, 20);
    t_rate(SPD_10, 1'b1, 1000, 10, 500, 500, 20, 20);
    t_mac;
    t_fifo;
    t_nibble;
    give_verdict;
  end

  initial begin
    #150000;
    fails++;
    $display("watchdog expired");
    give_verdict;
  end
endmodule // tb_rx_rate_adapt
